// >>> ccm_capture_compare.sv
// capture/compare module of the counter array: capture, match, toggle, pwm, frequency output
// assumes counter, array control register and interrupt controller live outside
`timescale 1ns/1ps
module ccm_capture_compare
  import ccm_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic [7:0]       sfr_addr,
  input  wire logic [7:0]       sfr_wdata,
  input  wire logic             sfr_wr,
  output logic      [7:0]       sfr_rdata,
  input  wire logic             value_low_wr,
  input  wire logic             value_high_wr,
  input  wire logic [7:0]       value_wdata,
  output logic      [7:0]       capture_value_low,
  output logic      [7:0]       capture_value_high,
  input  wire logic [CNT_W-1:0] counter_value,
  input  wire logic             flag_wr,
  input  wire logic             flag_wdata,
  output logic                  capture_compare_flag,
  output logic                  irq_req,
  input  wire logic             module_io_pin_in,
  output logic                  module_io_pin_out,
  output logic                  module_io_pin_oe,
  output logic                  pin_level
);
  // --------------------------------------------------------------------------
  // mode register
  // --------------------------------------------------------------------------
  logic [7:0]       mode_q;
  logic [CNT_W-1:0] value_q;
  logic             flag_q;
  logic             out_q;
  ccm_out_mode_e    out_mode;
  logic             cap_evt;
  logic             match_evt;
  logic             match_q;
  logic             pwm_high;
  ccm_edge_if       edge_bus();

  ccm_pin_sampler u_sampler (
    .clk    (clk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .pin_in (module_io_pin_in),
    .edge_o (edge_bus)
  );

  // full byte write, all fields read/write
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      mode_q <= CCM_MODE_RESET;
    else if (clk_en && sfr_wr && sfr_addr == CCM_MODE0_ADDR)
      mode_q <= sfr_wdata;
  end

  // unmapped addresses read as zero
  always_comb
  begin
    if (sfr_addr == CCM_MODE0_ADDR)
      sfr_rdata = mode_q;
    else
      sfr_rdata = 8'h00;
  end

  // --------------------------------------------------------------------------
  // capture path
  // --------------------------------------------------------------------------
  // edge qualified by its own enable; both set takes either
  assign cap_evt = (edge_bus.rise_seen & mode_q[CCM_BIT_RISE_CAP])
                 | (edge_bus.fall_seen & mode_q[CCM_BIT_FALL_CAP]);

  // capture beats a software write of the same cycle so no edge is lost
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      value_q <= '0;
    else if (clk_en)
    begin
      if (cap_evt)
        value_q <= counter_value;
      else if (value_low_wr)
        value_q[7:0] <= value_wdata;
      else if (value_high_wr)
        value_q[CNT_W-1:8] <= value_wdata;
    end
  end

  assign capture_value_low  = value_q[7:0];
  assign capture_value_high = value_q[CNT_W-1:8];
  assign pin_level          = edge_bus.pin_level;

  // --------------------------------------------------------------------------
  // compare path
  // --------------------------------------------------------------------------
  // match pulses once per counter equality, not every frozen cycle
  logic eq_now;
  assign eq_now    = mode_q[CCM_BIT_COMPARE_EN] && (counter_value == value_q);
  assign match_evt = clk_en & eq_now & ~match_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      match_q <= 1'b0;
    else if (clk_en)
      match_q <= eq_now;
  end

  // pwm: low-byte compare for 8-bit mode, full width for 16-bit; high while below
  always_comb
  begin
    if (mode_q[CCM_BIT_WIDE_PWM])
      pwm_high = counter_value < value_q;
    else
      pwm_high = counter_value[7:0] < value_q[7:0];
  end

  // decode of output waveform mode
  always_comb
  begin
    if (!mode_q[CCM_BIT_COMPARE_EN])
      out_mode = CCM_OUT_IDLE;
    else if (mode_q[CCM_BIT_TOGGLE_EN] && mode_q[CCM_BIT_PWM_EN])
      out_mode = CCM_OUT_FREQ;
    else if (mode_q[CCM_BIT_PWM_EN])
      out_mode = CCM_OUT_PWM;
    else if (mode_q[CCM_BIT_TOGGLE_EN])
      out_mode = CCM_OUT_TOGGLE;
    else
      out_mode = CCM_OUT_IDLE;
  end

  // frequency output toggles on match like toggle; the external counter reload
  // that sets the period is outside this block
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      out_q <= 1'b0;
    else if (clk_en)
    begin
      case (out_mode)
        CCM_OUT_TOGGLE: if (match_evt) out_q <= ~out_q;
        CCM_OUT_FREQ:   if (match_evt) out_q <= ~out_q;
        CCM_OUT_PWM:    out_q <= pwm_high;
        default:        out_q <= out_q;
      endcase
    end
  end

  assign module_io_pin_out = out_q;
  assign module_io_pin_oe  = (out_mode != CCM_OUT_IDLE);

  // --------------------------------------------------------------------------
  // flag and interrupt
  // --------------------------------------------------------------------------
  // hardware set wins over software clear; no clear on interrupt entry
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      flag_q <= 1'b0;
    else if (clk_en)
    begin
      if (cap_evt || (match_evt && mode_q[CCM_BIT_MATCH_EN]))
        flag_q <= 1'b1;
      else if (flag_wr)
        flag_q <= flag_wdata;
    end
  end

  assign capture_compare_flag = flag_q;
  assign irq_req              = flag_q & mode_q[CCM_BIT_FLAG_IE];

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  property p_capture_loads;
    @(posedge clk) disable iff (!rst_n)
    cap_evt |=> value_q == $past(counter_value);
  endproperty
  a_capture_loads: assert property (p_capture_loads)
    else $error("capture did not load counter");

  property p_edge_select;
    @(posedge clk) disable iff (!rst_n)
    (edge_bus.rise_seen && !mode_q[CCM_BIT_RISE_CAP] && !edge_bus.fall_seen) |-> !cap_evt;
  endproperty
  a_edge_select: assert property (p_edge_select)
    else $error("capture on disarmed rising edge");

  property p_capture_flag;
    @(posedge clk) disable iff (!rst_n)
    cap_evt |=> flag_q;
  endproperty
  a_capture_flag: assert property (p_capture_flag)
    else $error("capture did not set flag");

  property p_irq_mask;
    @(posedge clk) disable iff (!rst_n)
    irq_req == (flag_q && mode_q[CCM_BIT_FLAG_IE]);
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt not gated by enable");

  property p_flag_sticky;
    @(posedge clk) disable iff (!rst_n)
    (flag_q && !(flag_wr && !flag_wdata)) |=> flag_q;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("flag dropped without software clear");

  property p_mode_reset;
    @(posedge clk)
    !rst_n |=> mode_q == 8'h00;
  endproperty
  a_mode_reset: assert property (p_mode_reset)
    else $error("mode register not reset");

  property p_no_compare_idle;
    @(posedge clk) disable iff (!rst_n)
    !mode_q[CCM_BIT_COMPARE_EN] |-> !module_io_pin_oe;
  endproperty
  a_no_compare_idle: assert property (p_no_compare_idle)
    else $error("output driven with compare off");

  property p_match_flag;
    @(posedge clk) disable iff (!rst_n)
    (match_evt && mode_q[CCM_BIT_MATCH_EN]) |=> flag_q;
  endproperty
  a_match_flag: assert property (p_match_flag)
    else $error("match did not set flag");

  property p_toggle;
    @(posedge clk) disable iff (!rst_n)
    (match_evt && out_mode == CCM_OUT_TOGGLE) |=> out_q != $past(out_q);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("match did not toggle output");

  property p_set_wins;
    @(posedge clk) disable iff (!rst_n)
    (cap_evt && flag_wr && !flag_wdata) |=> flag_q;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat capture");

  property p_freq_toggle;
    @(posedge clk) disable iff (!rst_n)
    (match_evt && out_mode == CCM_OUT_FREQ) |=> out_q != $past(out_q);
  endproperty
  a_freq_toggle: assert property (p_freq_toggle)
    else $error("match did not toggle frequency output");

  property p_pwm_wide;
    @(posedge clk) disable iff (!rst_n)
    (clk_en && out_mode == CCM_OUT_PWM && mode_q[CCM_BIT_WIDE_PWM])
      |=> out_q == ($past(counter_value) < $past(value_q));
  endproperty
  a_pwm_wide: assert property (p_pwm_wide)
    else $error("wide pwm level wrong");

  property p_pwm_drives;
    @(posedge clk) disable iff (!rst_n)
    (mode_q[CCM_BIT_COMPARE_EN] && mode_q[CCM_BIT_PWM_EN]) |-> module_io_pin_oe;
  endproperty
  a_pwm_drives: assert property (p_pwm_drives)
    else $error("pwm mode not driving the pin");

  // level is the pin two running cycles back; reset or a freeze in between excuses it
  property p_level_readable;
    @(posedge clk) disable iff (!rst_n)
    ($past(rst_n) && $past(rst_n, 2) && $past(clk_en) && $past(clk_en, 2))
      |-> pin_level == $past(module_io_pin_in, 2);
  endproperty
  a_level_readable: assert property (p_level_readable)
    else $error("pin level is not the synchronised pin");

  c_capture:  cover property (@(posedge clk) disable iff (!rst_n) cap_evt);
  c_both:     cover property (@(posedge clk) disable iff (!rst_n)
    cap_evt && mode_q[CCM_BIT_RISE_CAP] && mode_q[CCM_BIT_FALL_CAP]);
  c_toggle:   cover property (@(posedge clk) disable iff (!rst_n)
    match_evt && out_mode == CCM_OUT_TOGGLE);
  c_pwm:      cover property (@(posedge clk) disable iff (!rst_n) out_mode == CCM_OUT_PWM);
  c_freq:     cover property (@(posedge clk) disable iff (!rst_n)
    match_evt && out_mode == CCM_OUT_FREQ);
endmodule // ccm_capture_compare

// >>> ccm_pkg.sv
// package for the capture/compare module: register offset, field positions, reset values
// assumes an 8-bit special-function-register bus and a shared 16-bit counter outside
package ccm_pkg;
  // --------------------------------------------------------------------------
  // register map
  // --------------------------------------------------------------------------
  localparam logic [7:0] CCM_MODE0_ADDR    = 8'hda;
  localparam logic [7:0] CCM_MODE_RESET    = 8'h00;
  localparam logic [7:0] CCM_VALUE_LOW_RST = 8'h00;
  // --------------------------------------------------------------------------
  // mode register field positions
  // --------------------------------------------------------------------------
  localparam int CCM_BIT_WIDE_PWM   = 7;
  localparam int CCM_BIT_COMPARE_EN = 6;
  localparam int CCM_BIT_RISE_CAP   = 5;
  localparam int CCM_BIT_FALL_CAP   = 4;
  localparam int CCM_BIT_MATCH_EN   = 3;
  localparam int CCM_BIT_TOGGLE_EN  = 2;
  localparam int CCM_BIT_PWM_EN     = 1;
  localparam int CCM_BIT_FLAG_IE    = 0;
  // --------------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------------
  localparam int CCM_MIN_HOLD_CYCLES = 2;
  localparam int CCM_SYNC_STAGES     = 2;
  // --------------------------------------------------------------------------
  // output waveform modes
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    CCM_OUT_IDLE   = 4'h1,
    CCM_OUT_TOGGLE = 4'h2,
    CCM_OUT_PWM    = 4'h4,
    CCM_OUT_FREQ   = 4'h8
  } ccm_out_mode_e;
endpackage

// >>> ccm_edge_if.sv
// interface between the top and the pin sampler
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface ccm_edge_if;
  logic pin_level;
  logic rise_seen;
  logic fall_seen;
  modport sampler (output pin_level, output rise_seen, output fall_seen);
  modport user    (input pin_level, input rise_seen, input fall_seen);
endinterface

// >>> ccm_pin_sampler.sv
// pin sampler: two-stage synchroniser then edge detection on settled samples
// assumes the pin is asynchronous to clk and held at least two cycles per level
`timescale 1ns/1ps
module ccm_pin_sampler
  import ccm_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst_n,
  input  wire logic   clk_en,
  input  wire logic   pin_in,
  ccm_edge_if.sampler edge_o
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // synchroniser; meta_q feeds sync_q only
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end
    else if (clk_en)
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // compare consecutive synchronised samples
  assign edge_o.pin_level = sync_q;
  assign edge_o.rise_seen = clk_en & sync_q & ~last_q;
  assign edge_o.fall_seen = clk_en & ~sync_q & last_q;

  // a frozen cycle leaves the samples as they were, so only a running cycle
  // before the edge says what the previous sample was
  property p_rise_needs_low;
    @(posedge clk) disable iff (!rst_n)
    (edge_o.rise_seen && $past(clk_en)) |-> $past(sync_q) == 1'b0;
  endproperty
  a_rise_needs_low: assert property (p_rise_needs_low)
    else $error("rise seen without low sample");

  property p_fall_needs_high;
    @(posedge clk) disable iff (!rst_n)
    (edge_o.fall_seen && $past(clk_en)) |-> $past(sync_q) == 1'b1;
  endproperty
  a_fall_needs_high: assert property (p_fall_needs_high)
    else $error("fall seen without high sample");
endmodule // ccm_pin_sampler

// >>> ccm_pin_source.sv
// far-side model of the module pin: a source that steps between levels
// assumes the bench requests levels and the design may drive the pin itself
`timescale 1ns/1ps
module ccm_pin_source
(
  input  wire logic clk,
  input  wire logic level_req,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      pin_wire
);
  logic drv_q;
  logic held_q;
  initial drv_q = 1'b0;
  initial held_q = 1'b0;
  // a new level is taken only once the old one has stood two cycles
  always @(posedge clk)
  begin
    if (held_q && level_req !== drv_q)
    begin
      drv_q <= #1 level_req;
      held_q <= #1 1'b0;
    end
    else
      held_q <= #1 1'b1;
  end
  // the design's own driver wins while its enable is high
  assign pin_wire = pin_oe ? pin_out : drv_q;
endmodule // ccm_pin_source

// >>> ccm_capture_compare_bench.sv
// self-checking bench for the capture/compare module
// assumes the bench owns the shared counter and the register strobes
`timescale 1ns/1ps
module ccm_capture_compare_bench
  import ccm_pkg::*;
;
  logic        clk, rst_n, sfr_wr, value_low_wr, value_high_wr;
  logic        flag_wr, flag_wdata, lvl, pin_wire, o, x, clk_en;
  logic        capture_compare_flag, irq_req, pin_level;
  logic        module_io_pin_out, module_io_pin_oe;
  logic [7:0]  sfr_addr, sfr_wdata, value_wdata, sfr_rdata;
  logic [7:0]  capture_value_low, capture_value_high;
  logic [15:0] cnt;
  int          error_cnt, samples_checked, cycles;
  logic [7:0]  pat [2] = '{8'ha5, 8'h5a};
  logic [7:0]  cm [3] = '{8'h20, 8'h10, 8'h31};
  logic [7:0]  tm [2] = '{8'h44, 8'h46};
  logic [7:0]  pm [4] = '{8'h42, 8'h42, 8'hc2, 8'hc2};
  logic [15:0] pc [4] = '{16'h0010, 16'h00f0, 16'h00f0, 16'h2000};
  logic        pe [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  ccm_capture_compare #(.CNT_W(16)) u_ccm_capture_compare
  (
    .clk, .rst_n, .clk_en, .sfr_addr, .sfr_wdata, .sfr_wr,
    .sfr_rdata, .value_low_wr, .value_high_wr, .value_wdata,
    .capture_value_low, .capture_value_high, .counter_value(cnt),
    .flag_wr, .flag_wdata, .capture_compare_flag, .irq_req,
    .module_io_pin_in(pin_wire), .module_io_pin_out,
    .module_io_pin_oe, .pin_level
  );
  ccm_pin_source u_ccm_pin_source
  (
    .clk, .level_req(lvl), .pin_out(module_io_pin_out),
    .pin_oe(module_io_pin_oe), .pin_wire
  );

  // ---------------------------------------------------------------
  // clock, watchdog and shared tasks
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // a hang shows as a run far past the few hundred cycles needed
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // sel 0 mode bus, 1 value low, 2 value high, 3 flag write
  task automatic wr(input logic [1:0] sel, input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    value_wdata = d;
    flag_wdata = d[0];
    sfr_wr = (sel == 2'd0);
    value_low_wr = (sel == 2'd1);
    value_high_wr = (sel == 2'd2);
    flag_wr = (sel == 2'd3);
    wait_cyc(1);
    {sfr_wr, value_low_wr, value_high_wr, flag_wr} = 4'h0;
    // idle cycle so a following write never raises a strobe in the same step
    wait_cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    wait_cyc(1);
    check("rdata", sfr_rdata, e);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // a level is held long enough for sync, edge and capture to land
  task automatic pin(input logic l);
    lvl = l;
    wait_cyc(8);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    {rst_n, sfr_wr, value_low_wr, value_high_wr, flag_wr, flag_wdata, lvl} = '0;
    {sfr_addr, sfr_wdata, value_wdata} = '0;
    cnt = '0;
    clk_en = 1'b1;
    error_cnt = 0;
    samples_checked = 0;
    cycles = 0;
    wait_cyc(3);
    rst_n = 1'b1;
    rd(CCM_MODE0_ADDR, CCM_MODE_RESET);
    check("flag", capture_compare_flag, 1'b0);
    check("irq", irq_req, 1'b0);
    check("oe", module_io_pin_oe, 1'b0);
    $display("test reset done");
    foreach (pat[i])
    begin
      wr(0, CCM_MODE0_ADDR, pat[i]);
      rd(CCM_MODE0_ADDR, pat[i]);
    end
    wr(0, 8'hdb, 8'hff);
    rd(CCM_MODE0_ADDR, pat[1]);
    rd(8'hdb, 8'h00);
    $display("test registers done");
    // each edge mode sees a rise then a fall, each with its own count
    foreach (cm[i])
    begin
      wr(0, CCM_MODE0_ADDR, cm[i]);
      pin(1'b0);
      for (int e = 0; e < 2; e++)
      begin
        wr(3, 8'h00, 8'h00);
        cnt = 16'h1100 + 16'(i * 2 + e);
        pin(e == 0);
        x = (e == 0) ? cm[i][CCM_BIT_RISE_CAP] : cm[i][CCM_BIT_FALL_CAP];
        check("flag", capture_compare_flag, x);
        check("irq", irq_req, x & cm[i][CCM_BIT_FLAG_IE]);
        check("level", pin_level, e == 0);
        if (x)
          check("cap", {capture_value_high, capture_value_low}, cnt);
      end
    end
    wait_cyc(20);
    check("sticky", capture_compare_flag, 1'b1);
    wr(3, 8'h00, 8'h00);
    check("clear", capture_compare_flag, 1'b0);
    $display("test capture done");
    wr(1, 8'h00, 8'h34);
    wr(2, 8'h00, 8'h12);
    check("val", {capture_value_high, capture_value_low}, 16'h1234);
    wr(0, CCM_MODE0_ADDR, 8'h08);
    cnt = 16'h1234;
    wait_cyc(4);
    check("nocmp", capture_compare_flag, 1'b0);
    cnt = 16'h0000;
    wr(0, CCM_MODE0_ADDR, 8'h48);
    wait_cyc(2);
    cnt = 16'h1234;
    wait_cyc(4);
    check("match", capture_compare_flag, 1'b1);
    $display("test match done");
    foreach (tm[i])
    begin
      wr(0, CCM_MODE0_ADDR, tm[i]);
      cnt = 16'h0000;
      wait_cyc(4);
      check("oe", module_io_pin_oe, 1'b1);
      repeat (2)
      begin
        o = module_io_pin_out;
        cnt = 16'h1234;
        wait_cyc(4);
        check("tog", module_io_pin_out, !o);
        cnt = 16'h0000;
        wait_cyc(4);
      end
    end
    $display("test toggle done");
    wr(1, 8'h00, 8'h80);
    foreach (pm[i])
    begin
      wr(0, CCM_MODE0_ADDR, pm[i]);
      cnt = pc[i];
      wait_cyc(4);
      check("pwm", module_io_pin_out, pe[i]);
    end
    $display("test pwm done");
    // a low enable freezes every register, so this write and this clear are lost
    clk_en = 1'b0;
    wr(0, CCM_MODE0_ADDR, 8'h00);
    wr(3, 8'h00, 8'h00);
    rd(CCM_MODE0_ADDR, pm[3]);
    check("frozen", capture_compare_flag, 1'b1);
    clk_en = 1'b1;
    $display("test freeze done");
    // a reset in mid-run brings the registers back to their reset values
    rst_n = 1'b0;
    wait_cyc(3);
    rst_n = 1'b1;
    rd(CCM_MODE0_ADDR, CCM_MODE_RESET);
    check("flag", capture_compare_flag, 1'b0);
    check("irq", irq_req, 1'b0);
    check("oe", module_io_pin_oe, 1'b0);
    $display("test second reset done");
    stop_test();
  end
endmodule // ccm_capture_compare_bench
